// ### shared/acs_pkg.sv
package acs_pkg;

   // ==========================================================
   // register word indices (byte address is four times these)
   localparam logic [3:0] ACS_REG_CTRL0  = 4'h0;
   localparam logic [3:0] ACS_REG_CTRL1  = 4'h1;
   localparam logic [3:0] ACS_REG_CTRL2  = 4'h2;
   localparam logic [3:0] ACS_REG_BLANK  = 4'h3;
   localparam logic [3:0] ACS_REG_TCTL   = 4'h4;
   localparam logic [3:0] ACS_REG_TIMER  = 4'h5;
   localparam logic [3:0] ACS_REG_CHCFG  = 4'h6;
   localparam logic [3:0] ACS_REG_RESULT = 4'h7;
   localparam logic [3:0] ACS_REG_ACC1   = 4'h8;
   localparam logic [3:0] ACS_REG_ACC2   = 4'h9;

   // ==========================================================
   // bit positions of the start, interrupt-flag and auto-start bits
   localparam int ACS_C0_START_BIT = 4;
   localparam int ACS_C0_INTR_BIT  = 8;
   localparam int ACS_BL_AUTO_BIT  = 6;

   // ==========================================================
   // conversion timing, in conversion clocks
   localparam logic [4:0] ACS_CONV_CLKS     = 5'h10;
   localparam logic [3:0] ACS_SAMPLE_CLKS   = 4'h4;
   localparam logic [3:0] ACS_LAST_CONV_CLK = 4'(ACS_CONV_CLKS - 5'h01);

   // ==========================================================
   // types
   typedef enum logic [1:0] {
      ACS_TRIG_PWM     = 2'h0,
      ACS_TRIG_CMP_TMR = 2'h1,
      ACS_TRIG_SW_TMR  = 2'h2,
      ACS_TRIG_IMMED   = 2'h3
   } acs_trig_t;

   typedef enum logic [2:0] {
      ACS_IDLE  = 3'b000,
      ACS_ARMED = 3'b001,
      ACS_WAIT  = 3'b011,
      ACS_CONV1 = 3'b010,
      ACS_GAP   = 3'b110,
      ACS_CONV2 = 3'b111
   } acs_state_t;

   typedef struct packed {
      logic       power_en;
      logic       fmt;
      logic       start;
      logic [3:0] ext_ch;
   } acs_ctrl0_t;

   typedef struct packed {
      logic [2:0] clk_sel;
      logic [1:0] ref_sel;
      logic [2:0] src_sel;
   } acs_ctrl1_t;

   typedef struct packed {
      acs_trig_t  trig_sel;
      logic [2:0] count;
   } acs_ctrl2_t;

   typedef struct packed {
      logic prescale;
      logic ext_start;
   } acs_tctl_t;

   typedef struct packed {
      logic [3:0] delay;
      logic [3:0] ch2_sel;
      logic       ch2_type;
      logic [3:0] ch1_sel;
      logic       ch1_type;
      logic       two_ch;
   } acs_chcfg_t;

   typedef struct packed {
      logic       power_en;
      logic [1:0] ref_sel;
      logic       ext_connect;
      logic [3:0] ext_ch;
      logic [2:0] int_sel;
      logic       sample;
      logic       convert;
   } acs_analog_t;

   localparam acs_ctrl0_t ACS_CTRL0_RST = 7'h00;
   localparam acs_ctrl1_t ACS_CTRL1_RST = 8'h00;
   localparam acs_ctrl2_t ACS_CTRL2_RST = 5'h00;
   localparam acs_chcfg_t ACS_CHCFG_RST = 15'h0000;

endpackage

// ### verilog/acs_sequencer.sv
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps

// Notes on behaviour
// [RL1] software pulses the manual start bit high then low to start one conversion
// [RL2] busy stays high during a conversion, falls at completion with result valid
// [RL3] source codes 001 to 100 pick an internal signal and cut the external pin
// [RL4] result alignment in the result register follows the format bit
// [RL5] reference source follows the two-bit reference field, set before conversions
// [RL6] software powers the converter after setting the clock divider
// [RL7] software sets the shared pin to analog before converting an external channel
// [RL8] two-channel bit 0 and nonzero count give single-channel automatic mode
// [RL9] rising auto-start arms a group; triggers then blank, time or convert at once
// [RL10] trigger field picks pwm edge, comparator timer, software timer or immediate
// [RL11] pwm-edge trigger waits the six-bit blanking time before each conversion
// [RL12] timer start source, prescale and reload come from timer control and value
// [RL13] a group holds the number of conversions in the three-bit count field, or of channel pairs in two-channel mode
// [RL14] immediate trigger inserts the inter-conversion delay between conversions
// [RL15] single-channel results add into the channel-one accumulator
// [RL16] group end clears auto-start by hardware and raises the interrupt flag
// [RL17] software may poll auto-start for clear instead of using the interrupt
// [RL18] two-channel bit 1 and nonzero count use per-channel type and selector
// [RL19] two-channel mode converts channel one, waits the interval, then channel two
// [RL20] each channel's results add into that channel's accumulator
// [RL21] software enables all three interrupt enables to take converter interrupts
// [RL22] one conversion takes 16 conversion clocks: 4 sampling then 12 converting
// [RL23] conversion clock is system clock divided by two to the clock select field
// [RL24] completion clears busy and sets the interrupt request flag
// [RL25] pwm edge during a conversion sets the repeated-trigger flag and is dropped
// [RL26] accumulators clear when a new automatic group is enabled
module acs_sequencer
   import acs_pkg::*;
(
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   // avalon-mm slave, word addressed
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // trigger pins
   input  wire logic        pwm_output_signal,
   input  wire logic        comparator_trigger_signal,
   // converter core
   input  wire logic [11:0] sar_data,
   output acs_analog_t      analog_ctl,
   output logic             converter_interrupt_flag
);

   // ==========================================================
   // bus slave: one wait state on every access
   logic        bus_ack;
   wire         bus_req = avs_read | avs_write;
   wire         wr_en   = avs_write & bus_ack;
   wire  [31:0] wd      = avs_writedata;
   wire         wr_ctrl0 = wr_en & (avs_address == ACS_REG_CTRL0);
   wire         wr_ctrl1 = wr_en & (avs_address == ACS_REG_CTRL1);
   wire         wr_ctrl2 = wr_en & (avs_address == ACS_REG_CTRL2);
   wire         wr_blank = wr_en & (avs_address == ACS_REG_BLANK);
   wire         wr_tctl  = wr_en & (avs_address == ACS_REG_TCTL);
   wire         wr_timer = wr_en & (avs_address == ACS_REG_TIMER);
   wire         wr_chcfg = wr_en & (avs_address == ACS_REG_CHCFG);

   assign avs_waitrequest = bus_req & ~bus_ack;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         bus_ack <= 1'b0;
      end else begin
         bus_ack <= bus_req & ~bus_ack;
      end
   end

   // ==========================================================
   // software registers
   acs_ctrl0_t  ctrl0;
   acs_ctrl1_t  ctrl1;
   acs_ctrl2_t  ctrl2;
   acs_tctl_t   tctl;
   acs_chcfg_t  chcfg;
   logic [5:0]  blank;
   logic [15:0] timer_val;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ctrl0     <= ACS_CTRL0_RST;
         ctrl1     <= ACS_CTRL1_RST;
         ctrl2     <= ACS_CTRL2_RST;
         tctl      <= 2'h0;
         chcfg     <= ACS_CHCFG_RST;
         blank     <= 6'h00;
         timer_val <= 16'h0000;
      end else begin
         if (wr_ctrl0) ctrl0 <= acs_ctrl0_t'(wd[6:0]);
         if (wr_ctrl1) ctrl1 <= acs_ctrl1_t'(wd[7:0]);
         if (wr_ctrl2) ctrl2 <= acs_ctrl2_t'(wd[4:0]);
         if (wr_tctl) tctl <= acs_tctl_t'(wd[1:0]);
         if (wr_chcfg) chcfg <= acs_chcfg_t'(wd[14:0]);
         if (wr_blank) blank <= wd[5:0];
         if (wr_timer) timer_val <= wd[15:0];
      end
   end

   // ==========================================================
   // trigger pins: two flops, then edge detect on the second
   logic [1:0] pwm_sync;
   logic [1:0] cmp_sync;
   logic       pwm_last;
   logic       cmp_last;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pwm_sync <= 2'h0;
         cmp_sync <= 2'h0;
         pwm_last <= 1'b0;
         cmp_last <= 1'b0;
      end else begin
         pwm_sync <= {pwm_sync[0], pwm_output_signal};
         cmp_sync <= {cmp_sync[0], comparator_trigger_signal};
         pwm_last <= pwm_sync[1];
         cmp_last <= cmp_sync[1];
      end
   end

   wire pwm_rise = pwm_sync[1] & ~pwm_last;
   wire cmp_rise = cmp_sync[1] & ~cmp_last;

   // ==========================================================
   // conversion clock: free divider, tick when the low bits wrap
   logic [6:0] div_cnt;
   wire  [6:0] div_mask  = 7'h7f >> (3'h7 - ctrl1.clk_sel);
   wire        adck_tick = &(div_cnt | ~div_mask); // RL23

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         div_cnt <= 7'h00;
      end else begin
         div_cnt <= div_cnt + 7'h01;
      end
   end

   // ==========================================================
   // conversion engine
   logic        busy;
   logic [3:0]  conv_cnt;
   logic [15:0] result;
   logic        conv_start;
   wire         conv_done = busy & adck_tick & (conv_cnt == ACS_LAST_CONV_CLK); // RL22

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         busy     <= 1'b0;
         conv_cnt <= 4'h0;
      end else if (conv_start) begin
         busy     <= 1'b1; // RL2
         conv_cnt <= 4'h0;
      end else if (conv_done) begin
         busy     <= 1'b0; // RL2 RL24
      end else if (busy & adck_tick) begin
         conv_cnt <= conv_cnt + 4'h1;
      end
   end

   // first partial conversion clock is absorbed into sampling
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         result <= 16'h0000;
      end else if (conv_done) begin
         result <= ctrl0.fmt ? {4'h0, sar_data} : {sar_data, 4'h0}; // RL4
      end
   end

   // ==========================================================
   // automatic sequencer
   acs_state_t  state;
   acs_state_t  next_state;
   logic [15:0] wcnt;
   logic [15:0] next_wcnt;
   logic [2:0]  grp_cnt;
   logic        auto_start;
   logic        rpt_flag;
   logic        auto_go;
   logic [15:0] acc1;
   logic [15:0] acc2;

   wire auto_mode = (ctrl2.count != 3'h0);                         // RL8 RL18
   wire two_mode  = auto_mode & chcfg.two_ch;                       // RL18
   wire auto_rise = wr_blank & wd[ACS_BL_AUTO_BIT] & ~auto_start
                    & (state == ACS_IDLE);                          // RL9
   wire trig_pwm  = (ctrl2.trig_sel == ACS_TRIG_PWM);
   wire trig_imm  = (ctrl2.trig_sel == ACS_TRIG_IMMED);
   wire trig_tmr  = (ctrl2.trig_sel == ACS_TRIG_SW_TMR) |
                    (ctrl2.trig_sel == ACS_TRIG_CMP_TMR);
   // comparator-started timer only waits for the edge when selected
   wire arm_wait  = trig_imm | (trig_tmr & ~(tctl.ext_start &
                    (ctrl2.trig_sel == ACS_TRIG_CMP_TMR)));         // RL12
   wire arm_event = trig_pwm ? (pwm_rise & ~busy) : cmp_rise;      // RL10
   wire [15:0] wait_load = trig_pwm ? {10'h000, blank} :           // RL11
                           trig_imm ? {12'h000, chcfg.delay} :     // RL14
                           timer_val;                               // RL12
   wire timer_tick = tctl.prescale ? adck_tick : 1'b1;             // RL12
   wire step = (state == ACS_WAIT && trig_tmr) ? timer_tick : adck_tick;
   wire member_done = conv_done & ((state == ACS_CONV2) |
                      ((state == ACS_CONV1) & ~chcfg.two_ch));
   wire group_end = member_done & (3'(grp_cnt + 3'h1) == ctrl2.count); // RL13
   wire manual_go = wr_ctrl0 & ctrl0.start & ~wd[ACS_C0_START_BIT] &
                    ctrl0.power_en & ~auto_mode & ~busy;            // RL1

   assign conv_start = manual_go | auto_go;

   always_comb begin
      next_state = state;
      next_wcnt  = wcnt;
      auto_go    = 1'b0;
      case (state)
         ACS_IDLE: begin
            if (auto_rise) begin
               if (trig_imm) begin
                  next_state = ACS_CONV1; // RL10
                  auto_go    = 1'b1;
               end else if (arm_wait) begin
                  next_state = ACS_WAIT;
                  next_wcnt  = wait_load;
               end else begin
                  next_state = ACS_ARMED;
               end
            end
         end
         ACS_ARMED: begin
            if (!auto_start) begin
               next_state = ACS_IDLE;
            end else if (arm_event) begin
               next_state = ACS_WAIT; // RL9
               next_wcnt  = wait_load;
            end
         end
         ACS_WAIT, ACS_GAP: begin
            // clearing auto-start outside a conversion aborts at once
            if (!auto_start) begin
               next_state = ACS_IDLE;
            end else if (step && wcnt == 16'h0000) begin
               next_state = (state == ACS_GAP) ? ACS_CONV2 : ACS_CONV1; // RL19
               auto_go    = 1'b1;
            end else if (step) begin
               next_wcnt = wcnt - 16'h0001;
            end
         end
         ACS_CONV1, ACS_CONV2: begin
            // a cleared auto-start lets the running conversion finish
            if (conv_done) begin
               if (!auto_start || group_end) begin
                  next_state = ACS_IDLE;
               end else if (state == ACS_CONV1 && chcfg.two_ch) begin
                  next_state = ACS_GAP; // RL19
                  next_wcnt  = {12'h000, chcfg.delay};
               end else if (arm_wait) begin
                  next_state = ACS_WAIT; // RL14
                  next_wcnt  = wait_load;
               end else begin
                  next_state = ACS_ARMED;
               end
            end
         end
         default: begin
            next_state = ACS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state <= ACS_IDLE;
         wcnt  <= 16'h0000;
      end else begin
         state <= next_state;
         wcnt  <= next_wcnt;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         grp_cnt <= 3'h0;
      end else if (auto_rise) begin
         grp_cnt <= 3'h0;
      end else if (member_done) begin
         grp_cnt <= 3'(grp_cnt + 3'h1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         auto_start <= 1'b0;
      end else if (group_end) begin
         auto_start <= 1'b0; // RL16
      end else if (wr_blank) begin
         auto_start <= wd[ACS_BL_AUTO_BIT] & ((state == ACS_IDLE) | auto_start);
      end
   end

   // repeated trigger: the set wins over the arm-time clear
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rpt_flag <= 1'b0;
      end else if (auto_start & trig_pwm & pwm_rise & busy) begin
         rpt_flag <= 1'b1; // RL25
      end else if (auto_rise) begin
         rpt_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         acc1 <= 16'h0000;
         acc2 <= 16'h0000;
      end else if (auto_rise) begin
         acc1 <= 16'h0000; // RL26
         acc2 <= 16'h0000;
      end else if (conv_done && state == ACS_CONV1) begin
         acc1 <= acc1 + {4'h0, sar_data}; // RL15 RL20
      end else if (conv_done && state == ACS_CONV2) begin
         acc2 <= acc2 + {4'h0, sar_data}; // RL20
      end
   end

   // interrupt flag: write one to clear, a new set wins
   wire intr_set = (conv_done & (state == ACS_IDLE)) | group_end; // RL16 RL24

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         converter_interrupt_flag <= 1'b0;
      end else if (intr_set) begin
         converter_interrupt_flag <= 1'b1;
      end else if (wr_ctrl0 & wd[ACS_C0_INTR_BIT]) begin
         converter_interrupt_flag <= 1'b0;
      end
   end

   // ==========================================================
   // input routing to the analog front end
   function automatic logic [2:0] int_code(input logic [3:0] sel);
      case (sel)
         4'h1:    int_code = 3'h2;
         4'h2:    int_code = 3'h3;
         4'h3:    int_code = 3'h4;
         default: int_code = 3'h1;
      endcase
   endfunction

   wire        on_ch2   = (state == ACS_CONV2);
   wire [3:0]  ch_sel   = on_ch2 ? chcfg.ch2_sel : chcfg.ch1_sel;
   wire        ch_type  = on_ch2 ? chcfg.ch2_type : chcfg.ch1_type;
   wire        src_int  = (ctrl1.src_sel >= 3'h1) & (ctrl1.src_sel <= 3'h4);
   wire        ext_sel  = two_mode ? ch_type : ~src_int;           // RL3 RL18
   wire [2:0]  int_sel  = ext_sel ? 3'h0 :
                          (two_mode ? int_code(ch_sel) : ctrl1.src_sel);

   assign analog_ctl.power_en    = ctrl0.power_en;
   assign analog_ctl.ref_sel     = ctrl1.ref_sel; // RL5
   assign analog_ctl.ext_connect = ext_sel;
   assign analog_ctl.ext_ch      = two_mode ? ch_sel : ctrl0.ext_ch;
   assign analog_ctl.int_sel     = int_sel;
   assign analog_ctl.sample      = busy & (conv_cnt < ACS_SAMPLE_CLKS); // RL22
   assign analog_ctl.convert     = busy & (conv_cnt >= ACS_SAMPLE_CLKS);

   // ==========================================================
   // read mux, captured one cycle before the answer
   wire [31:0] rd_mux =
      (avs_address == ACS_REG_CTRL0)  ? {23'h0, converter_interrupt_flag, busy, ctrl0} :
      (avs_address == ACS_REG_CTRL1)  ? {24'h0, ctrl1} :
      (avs_address == ACS_REG_CTRL2)  ? {27'h0, ctrl2} :
      (avs_address == ACS_REG_BLANK)  ? {24'h0, rpt_flag, auto_start, blank} :
      (avs_address == ACS_REG_TCTL)   ? {30'h0, tctl} :
      (avs_address == ACS_REG_TIMER)  ? {16'h0, timer_val} :
      (avs_address == ACS_REG_CHCFG)  ? {17'h0, chcfg} :
      (avs_address == ACS_REG_RESULT) ? {16'h0, result} :
      (avs_address == ACS_REG_ACC1)   ? {16'h0, acc1} :
      (avs_address == ACS_REG_ACC2)   ? {16'h0, acc2} : 32'h0;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         avs_readdata <= 32'h0;
      end else if (avs_read & ~bus_ack) begin
         avs_readdata <= rd_mux;
      end
   end

   // ==========================================================
   // checks
   chk_conv_length: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL22
      $fell(busy) |-> $past(conv_cnt) == 4'hf)
      else $error("conversion ended before its sixteenth clock");

   chk_busy_start: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL2
      conv_start |=> busy && conv_cnt == 4'h0)
      else $error("busy not raised by a conversion start");

   chk_src_internal: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL3
      (!two_mode && src_int) |-> !analog_ctl.ext_connect && analog_ctl.int_sel == ctrl1.src_sel)
      else $error("external pin left connected for internal source");

   chk_result_fmt: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL4
      conv_done |=> result == ($past(ctrl0.fmt) ? {4'h0, $past(sar_data)}
                                                : {$past(sar_data), 4'h0}))
      else $error("result alignment wrong");

   chk_group_end: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL16
      group_end |=> !auto_start && converter_interrupt_flag && state == ACS_IDLE)
      else $error("group end did not clear auto-start or set flag");

   chk_rpt_trig: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL25
      (auto_start && trig_pwm && pwm_rise && busy) |=> rpt_flag)
      else $error("repeated trigger not flagged");

   chk_acc_clear: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL26
      auto_rise |=> acc1 == 16'h0000 && acc2 == 16'h0000 && grp_cnt == 3'h0)
      else $error("accumulators not cleared at group arm");

   chk_undivided: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL23
      (ctrl1.clk_sel == 3'h0) |-> adck_tick)
      else $error("undivided conversion clock missed a tick");

   // a divide-by-two clock must tick on every other system clock
   chk_halved_clock: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL23
      (ctrl1.clk_sel == 3'h1 && $past(ctrl1.clk_sel) == 3'h1) |-> adck_tick != $past(adck_tick))
      else $error("halved conversion clock did not alternate");

   chk_two_order: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL19
      (conv_done && state == ACS_CONV1 && chcfg.two_ch && auto_start && !group_end)
      |=> state == ACS_GAP && wcnt == {12'h000, $past(chcfg.delay)})
      else $error("channel two not preceded by interval");

   chk_manual_done: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL24
      (conv_done && state == ACS_IDLE) |=> !busy && converter_interrupt_flag)
      else $error("manual completion did not set flag");

endmodule

// ### testbench/acs_analog_model.sv
`timescale 1ns/100ps

// ==========
// analog mux and converter stand-in
module acs_analog_model
   import acs_pkg::*;
(
   // clock
   input  wire logic        clk_sys,
   // converter side
   input  wire acs_analog_t analog_ctl,
   output logic      [11:0] sar_data
);
   // the code names the routed input, so a wrong route shows in the result
   wire logic [11:0] routed = {analog_ctl.ref_sel, analog_ctl.ext_connect,
      analog_ctl.ext_connect ? analog_ctl.ext_ch : 4'h0,
      analog_ctl.ext_connect ? 3'h0 : analog_ctl.int_sel, 2'h1};

   initial sar_data = 12'h000;

   // outside a conversion the data toggles, so a stale capture cannot match
   always @(posedge clk_sys) begin
      // a powered-down converter gives garbage, so a missing enable shows
      sar_data <= (analog_ctl.convert & analog_ctl.power_en) ? routed : ~sar_data;
   end
endmodule

// ### testbench/acs_sequencer_bench.sv
`timescale 1ns/100ps

module acs_sequencer_bench
   import acs_pkg::*;
;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic        pwm = 1'b0;
   logic        cmp = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic [31:0] rd;
   logic        avs_waitrequest;
   logic        converter_interrupt_flag;
   logic [11:0] sar_data;
   logic [11:0] d1;
   logic [11:0] d2;
   acs_analog_t analog_ctl;
   logic [2:0]  src;
   logic [2:0]  cnt;
   logic [2:0]  is2;
   logic [3:0]  ch;
   logic [3:0]  s2;
   logic [1:0]  rs;
   logic        fmt;
   logic        ext;
   int          failures = 0;
   int          compares = 0;
   int          cycles = 0;
   integer      seed = 32'h4ed7;

   always #2 clk_sys = ~clk_sys;

   acs_sequencer u_acs_sequencer (.clk_sys(clk_sys), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .pwm_output_signal(pwm),
      .comparator_trigger_signal(cmp), .sar_data(sar_data),
      .analog_ctl(analog_ctl), .converter_interrupt_flag(converter_interrupt_flag));

   acs_analog_model u_acs_analog_model (.clk_sys(clk_sys), .analog_ctl(analog_ctl),
      .sar_data(sar_data));

   // ==========
   // helpers
   task end_sim;
      $display("counts: failures=%0d compares=%0d", failures, compares);
      if (failures == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task poll(input logic [3:0] a, input int b, input logic v);
      do bus(1'b0, a, 32'h0); while (rd[b] !== v);
   endtask

   // pin held four cycles so the two-flop sync cannot miss it
   task pulse(input int which);
      pwm <= (which == 0);
      cmp <= (which == 1);
      repeat (4) @(posedge clk_sys);
      pwm <= 1'b0;
      cmp <= 1'b0;
   endtask

   function automatic logic [11:0] code(logic e, logic [3:0] c, logic [2:0] i, logic [1:0] r);
      return {r, e, e ? c : 4'h0, e ? 3'h0 : i, 2'h1};
   endfunction

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         end_sim();
      end
   end

   // ==========
   // main sequence
   initial begin
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (int i = 0; i < 11; i++) begin
         bus(1'b0, 4'(i), 32'h0);
         check("reset value", 32'h0, rd);
      end
      for (int n = 0; n < 8; n++) begin
         src = 3'($random(seed));
         ch = 4'($random(seed));
         rs = 2'($random(seed));
         fmt = 1'($random(seed));
         ext = !(src inside {[3'h1:3'h4]});
         bus(1'b1, ACS_REG_CTRL1, {24'h0, 3'(n % 3), rs, src});
         bus(1'b1, ACS_REG_CTRL0, {25'h0, 1'b1, fmt, 1'b1, ch});
         bus(1'b1, ACS_REG_CTRL0, {25'h0, 1'b1, fmt, 1'b0, ch});
         check("ext connect", 32'(ext), 32'(analog_ctl.ext_connect));
         bus(1'b0, ACS_REG_CTRL0, 32'h0);
         check("busy", 32'h1, 32'(rd[7]));
         poll(ACS_REG_CTRL0, 7, 1'b0);
         d1 = code(ext, ch, src, rs);
         bus(1'b0, ACS_REG_RESULT, 32'h0);
         check("result", fmt ? {20'h0, d1} : {16'h0, d1, 4'h0}, rd);
         check("flag", 32'h1, 32'(converter_interrupt_flag));
         bus(1'b1, ACS_REG_CTRL0, 32'h140);
      end
      bus(1'b1, ACS_REG_CTRL1, 32'h0a);
      bus(1'b1, ACS_REG_TCTL, 32'h1);
      bus(1'b1, ACS_REG_TIMER, 32'h3);
      d1 = code(1'b0, 4'h0, 3'h2, 2'h1);
      for (int t = 0; t < 4; t++) begin
         cnt = (t == 3) ? 3'($unsigned($random(seed)) % 7 + 1) : 3'h1;
         bus(1'b1, ACS_REG_CTRL2, {27'h0, 2'(t), cnt});
         bus(1'b1, ACS_REG_BLANK, 32'h45);
         if (t < 2) pulse(t);
         if (t == 0) begin
            poll(ACS_REG_CTRL0, 7, 1'b1);
            pulse(0);
         end
         poll(ACS_REG_BLANK, 6, 1'b0);
         bus(1'b0, ACS_REG_ACC1, 32'h0);
         check("acc1", {16'h0, 16'(d1) * 16'(cnt)}, rd);
         bus(1'b0, ACS_REG_BLANK, 32'h0);
         check("repeat flag", 32'(t == 0), 32'(rd[7]));
         check("flag", 32'h1, 32'(converter_interrupt_flag));
         bus(1'b1, ACS_REG_CTRL0, 32'h140);
      end
      ch = 4'($random(seed));
      s2 = 4'($random(seed));
      is2 = (s2 == 4'h1) ? 3'h2 : (s2 == 4'h2) ? 3'h3 : (s2 == 4'h3) ? 3'h4 : 3'h1;
      cnt = 3'($unsigned($random(seed)) % 7 + 1);
      bus(1'b1, ACS_REG_CHCFG, {17'h0, 4'h2, s2, 1'b0, ch, 2'h3});
      bus(1'b1, ACS_REG_CTRL2, {27'h0, 2'h3, cnt});
      bus(1'b1, ACS_REG_BLANK, 32'h40);
      poll(ACS_REG_BLANK, 6, 1'b0);
      d1 = code(1'b1, ch, 3'h0, 2'h1);
      d2 = code(1'b0, 4'h0, is2, 2'h1);
      bus(1'b0, ACS_REG_ACC1, 32'h0);
      check("acc1 two", {16'h0, 16'(d1) * 16'(cnt)}, rd);
      bus(1'b0, ACS_REG_ACC2, 32'h0);
      check("acc2 two", {16'h0, 16'(d2) * 16'(cnt)}, rd);
      end_sim();
   end
endmodule
